// ==== include/pin_mux_pkg.sv ====
// Purpose: Shared constants and types for the port E pin function selector.
// Assumes: 16-bit register data, byte offsets on a plain strobe port.
// Notes:   Mode fields are three bits wide in four-bit slots; slot bit 3 is reserved.

package pin_mux_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Bus geometry
	localparam int ADDR_W   = 8;
	localparam int DATA_W   = 16;
	localparam int PIN_W    = 16;

	////////////////////////////////////////////////////////////////////////////////
	// Register offsets
	localparam logic [ADDR_W-1:0] OFS_DIRECTION  = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_SEL_UPPER  = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_SEL_LOWER  = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_PORT_DATA  = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_PIN_STATE  = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_ROUTE_STAT = 8'h14;

	////////////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [DATA_W-1:0] RST_DIRECTION = 16'h0000;
	localparam logic [DATA_W-1:0] RST_SEL_UPPER = 16'h0000;
	localparam logic [DATA_W-1:0] RST_SEL_LOWER = 16'h0000;
	localparam logic [DATA_W-1:0] RST_PORT_DATA = 16'h0000;
	localparam logic [DATA_W-1:0] RST_ZERO      = 16'h0000;

	////////////////////////////////////////////////////////////////////////////////
	// Field layout
	localparam int MODE_W        = 3;
	localparam int SLOT_W        = 4;
	localparam int SLOTS         = 4;
	localparam int LOWER_BASE    = 4;
	localparam int UPPER_BASE    = 8;
	localparam logic [DATA_W-1:0] SEL_WRITE_MASK = 16'h7777;

	// Pins carrying serial functions
	localparam int PIN_RXD = 11;
	localparam int PIN_TXD = 5;
	localparam int PIN_SCK = 6;

	// Route status bit positions
	localparam int STAT_RXD = 0;
	localparam int STAT_TXD = 1;
	localparam int STAT_SCK = 2;

	// Synchroniser depth for pin inputs
	localparam int SYNC_STAGES = 3;

	////////////////////////////////////////////////////////////////////////////////
	// Mode codes
	typedef logic [MODE_W-1:0] pin_mode_t;
	localparam pin_mode_t MODE_PORT = 3'h0;
	localparam pin_mode_t MODE_TXD  = 3'h2;
	localparam pin_mode_t MODE_SCK  = 3'h2;
	localparam pin_mode_t MODE_RXD  = 3'h3;

	// Idle levels of the receive and clock inputs while no pin feeds them
	localparam logic RXD_IDLE = 1'b1;
	localparam logic SCK_IDLE = 1'b0;

endpackage : pin_mux_pkg

// ==== include/pin_sync_if.sv ====
// Purpose: Carries raw pin levels to the filter and filtered levels back.
// Assumes: One clock domain on the filtered side.
// Notes:   Only the main module and the filter use it.

`timescale 1ns/1ps

interface pin_sync_if #(
	parameter int W = 16
);
	logic [W-1:0] raw;
	logic [W-1:0] level;

	modport filter (input raw, output level);
	modport user   (output raw, input level);
endinterface : pin_sync_if

// ==== hdl/pin_input_filter.sv ====
// Purpose: Three-stage synchroniser with agreement filter for port pins.
// Assumes: Pins are asynchronous to ref_clk.
// Notes:   A new level is taken only when stages two and three agree.

`timescale 1ns/1ps

module pin_input_filter
	import pin_mux_pkg::*;
#(
	parameter int W = PIN_W
) (
	input  wire logic  ref_clk,
	input  wire logic  reset,
	pin_sync_if.filter sync
);

	logic [W-1:0] stage1_r;
	logic [W-1:0] stage2_r;
	logic [W-1:0] stage3_r;
	logic [W-1:0] level_r;
	logic [W-1:0] level_nxt;

	////////////////////////////////////////////////////////////////////////////////
	// Stage one feeds only stage two, so no logic sees a metastable value
	always_comb begin
		level_nxt = level_r;
		for (int i = 0; i < W; i++) begin
			if (stage2_r[i] == stage3_r[i]) begin
				level_nxt[i] = stage3_r[i];
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			stage1_r <= '0;
			stage2_r <= '0;
			stage3_r <= '0;
			level_r  <= '0;
		end else begin
			stage1_r <= sync.raw;
			stage2_r <= stage1_r;
			stage3_r <= stage2_r;
			level_r  <= level_nxt;
		end
	end

	assign sync.level = level_r;

endmodule : pin_input_filter

// ==== hdl/port_e_pin_function_select.sv ====
// Purpose: Direction and function selection for a sixteen-pin port with serial routing.
// Assumes: Single ref_clk domain; pins asynchronous; serial channel on ref_clk.
// Notes:   Pin outputs and enables are registered, so they lag a register write by one cycle.
//
// Design decisions made here: the address-and-strobe port and the address map.

`timescale 1ns/1ps

// Function
// RULE_01: Each pin has a direction bit at its own bit position, 0 for input and 1 for output.
// RULE_02: Each multiplexed pin has a three-bit mode in a four-bit slot, and mode 000 gives plain port I/O.
// RULE_03: Pin 11 with mode 011 in bits 14 to 12 of the upper select feeds the serial receive input.
// RULE_04: Pin 5 with mode 010 in bits 6 to 4 of the lower select is driven by serial transmit data.
// RULE_05: Pin 6 with mode 010 in bits 10 to 8 of the lower select carries the two-way serial clock.
// RULE_06: Reserved bits 15, 11, 7 and 3 of the select registers read zero and ignore writes.
module port_e_pin_function_select
	import pin_mux_pkg::*;
#(
	parameter int PINS = PIN_W
) (
	input  wire logic              ref_clk,
	input  wire logic              reset,
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [DATA_W-1:0] reg_wdata,
	input  wire logic              reg_write,
	input  wire logic              reg_read,
	output logic      [DATA_W-1:0] reg_rdata,
	input  wire logic [PINS-1:0]   pin_in,
	output logic      [PINS-1:0]   pin_out,
	output logic      [PINS-1:0]   pin_oe,
	input  wire logic              serial_transmit_line,
	input  wire logic              serial_clock_out,
	input  wire logic              serial_clock_oe,
	output logic                   serial_receive_line,
	output logic                   serial_clock_in
);

	////////////////////////////////////////////////////////////////////////////////
	// Register state
	logic [DATA_W-1:0] port_e_direction_low_r;
	logic [DATA_W-1:0] port_e_direction_low_nxt;
	logic [DATA_W-1:0] port_e_function_select_upper_r;
	logic [DATA_W-1:0] port_e_function_select_upper_nxt;
	logic [DATA_W-1:0] port_e_function_select_lower_r;
	logic [DATA_W-1:0] port_e_function_select_lower_nxt;
	logic [DATA_W-1:0] port_data_r;
	logic [DATA_W-1:0] port_data_nxt;
	logic [DATA_W-1:0] rdata_r;
	logic [DATA_W-1:0] rdata_nxt;

	////////////////////////////////////////////////////////////////////////////////
	// Pin side state
	logic [PINS-1:0]   pin_out_r;
	logic [PINS-1:0]   pin_out_nxt;
	logic [PINS-1:0]   pin_oe_r;
	logic [PINS-1:0]   pin_oe_nxt;
	logic              receive_r;
	logic              receive_nxt;
	logic              clock_in_r;
	logic              clock_in_nxt;

	pin_mode_t         pin_mode [PINS];
	logic              rxd_sel;
	logic              txd_sel;
	logic              sck_sel;
	logic [DATA_W-1:0] route_status;

	pin_sync_if #(.W(PINS)) sync ();

	////////////////////////////////////////////////////////////////////////////////
	// Input synchroniser
	assign sync.raw = pin_in;

	pin_input_filter #(
		.W       (PINS)
	) u_filter (
		.ref_clk (ref_clk),
		.reset   (reset),
		.sync    (sync)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Mode field extraction; pins outside 4..11 have no field and stay port pins
	genvar gp;
	generate
		for (gp = 0; gp < PINS; gp++) begin : g_mode
			if (gp >= UPPER_BASE && gp < UPPER_BASE + SLOTS) begin : g_upper
				assign pin_mode[gp] =
					port_e_function_select_upper_r[(gp - UPPER_BASE) * SLOT_W +: MODE_W]; // RULE_02
			end else if (gp >= LOWER_BASE && gp < LOWER_BASE + SLOTS) begin : g_lower
				assign pin_mode[gp] =
					port_e_function_select_lower_r[(gp - LOWER_BASE) * SLOT_W +: MODE_W]; // RULE_02
			end else begin : g_fixed
				assign pin_mode[gp] = MODE_PORT;
			end
		end
	endgenerate

	assign rxd_sel = (pin_mode[PIN_RXD] == MODE_RXD); // RULE_03
	assign txd_sel = (pin_mode[PIN_TXD] == MODE_TXD); // RULE_04
	assign sck_sel = (pin_mode[PIN_SCK] == MODE_SCK); // RULE_05

	////////////////////////////////////////////////////////////////////////////////
	// Per-pin drive; peripheral functions override the direction bit so a
	// serial pin cannot be stranded by a stale port setting
	generate
		for (gp = 0; gp < PINS; gp++) begin : g_drive
			if (gp == PIN_TXD) begin : g_txd
				assign pin_out_nxt[gp] = txd_sel ? serial_transmit_line : port_data_r[gp]; // RULE_04
				assign pin_oe_nxt[gp]  = txd_sel ? 1'b1 : port_e_direction_low_r[gp]; // RULE_04
			end else if (gp == PIN_SCK) begin : g_sck
				assign pin_out_nxt[gp] = sck_sel ? serial_clock_out : port_data_r[gp]; // RULE_05
				assign pin_oe_nxt[gp]  = sck_sel ? serial_clock_oe : port_e_direction_low_r[gp]; // RULE_05
			end else if (gp == PIN_RXD) begin : g_rxd
				assign pin_out_nxt[gp] = port_data_r[gp];
				assign pin_oe_nxt[gp]  = rxd_sel ? 1'b0 : port_e_direction_low_r[gp]; // RULE_03
			end else begin : g_port
				assign pin_out_nxt[gp] = port_data_r[gp]; // RULE_02
				assign pin_oe_nxt[gp]  = port_e_direction_low_r[gp]; // RULE_01
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Serial inputs; unrouted lines hold their idle level so the channel sees no false start
	always_comb begin
		receive_nxt  = rxd_sel ? sync.level[PIN_RXD] : RXD_IDLE; // RULE_03
		clock_in_nxt = sck_sel ? sync.level[PIN_SCK] : SCK_IDLE; // RULE_05
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			pin_out_r  <= '0;
			pin_oe_r   <= '0;
			receive_r  <= RXD_IDLE;
			clock_in_r <= SCK_IDLE;
		end else begin
			pin_out_r  <= pin_out_nxt;
			pin_oe_r   <= pin_oe_nxt;
			receive_r  <= receive_nxt;
			clock_in_r <= clock_in_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register writes
	always_comb begin
		port_e_direction_low_nxt         = port_e_direction_low_r;
		port_e_function_select_upper_nxt = port_e_function_select_upper_r;
		port_e_function_select_lower_nxt = port_e_function_select_lower_r;
		port_data_nxt                    = port_data_r;
		if (reg_write) begin
			case (reg_addr)
				OFS_DIRECTION: begin
					port_e_direction_low_nxt = reg_wdata; // RULE_01
				end
				OFS_SEL_UPPER: begin
					port_e_function_select_upper_nxt = reg_wdata & SEL_WRITE_MASK; // RULE_06
				end
				OFS_SEL_LOWER: begin
					port_e_function_select_lower_nxt = reg_wdata & SEL_WRITE_MASK; // RULE_06
				end
				OFS_PORT_DATA: begin
					port_data_nxt = reg_wdata;
				end
				default: begin
					port_data_nxt = port_data_r;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			port_e_direction_low_r         <= RST_DIRECTION;
			port_e_function_select_upper_r <= RST_SEL_UPPER;
			port_e_function_select_lower_r <= RST_SEL_LOWER;
			port_data_r                    <= RST_PORT_DATA;
		end else begin
			port_e_direction_low_r         <= port_e_direction_low_nxt;
			port_e_function_select_upper_r <= port_e_function_select_upper_nxt;
			port_e_function_select_lower_r <= port_e_function_select_lower_nxt;
			port_data_r                    <= port_data_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register reads; data stand only in the cycle after the strobe
	always_comb begin
		route_status           = RST_ZERO;
		route_status[STAT_RXD] = rxd_sel;
		route_status[STAT_TXD] = txd_sel;
		route_status[STAT_SCK] = sck_sel;
	end

	always_comb begin
		rdata_nxt = RST_ZERO;
		if (reg_read) begin
			case (reg_addr)
				OFS_DIRECTION:  rdata_nxt = port_e_direction_low_r;
				OFS_SEL_UPPER:  rdata_nxt = port_e_function_select_upper_r & SEL_WRITE_MASK; // RULE_06
				OFS_SEL_LOWER:  rdata_nxt = port_e_function_select_lower_r & SEL_WRITE_MASK; // RULE_06
				OFS_PORT_DATA:  rdata_nxt = port_data_r;
				OFS_PIN_STATE:  rdata_nxt = sync.level;
				OFS_ROUTE_STAT: rdata_nxt = route_status;
				default:        rdata_nxt = RST_ZERO;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			rdata_r <= RST_ZERO;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign reg_rdata           = rdata_r;
	assign pin_out             = pin_out_r;
	assign pin_oe              = pin_oe_r;
	assign serial_receive_line = receive_r;
	assign serial_clock_in     = clock_in_r;

endmodule : port_e_pin_function_select

// ==== test/pin_select_properties.sv ====
// Purpose: Port-level properties of the port E pin function selector.
// Assumes: Strobes stay low while reset is high.
// Notes:   Pin outputs follow a register write two edges later.
`timescale 1ns/1ps
module pin_select_properties
	import pin_mux_pkg::*;
#(
	parameter int PINS = PIN_W
) (
	input wire logic              ref_clk,
	input wire logic              reset,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic              reg_write,
	input wire logic              reg_read,
	input wire logic [DATA_W-1:0] reg_rdata,
	input wire logic [PINS-1:0]   pin_in,
	input wire logic [PINS-1:0]   pin_out,
	input wire logic [PINS-1:0]   pin_oe,
	input wire logic              serial_transmit_line,
	input wire logic              serial_clock_out,
	input wire logic              serial_clock_oe,
	input wire logic              serial_receive_line,
	input wire logic              serial_clock_in
);
	logic wr_dir;
	logic wr_up;
	logic wr_lo;
	assign wr_dir = reg_write && reg_addr == OFS_DIRECTION;
	assign wr_up  = reg_write && reg_addr == OFS_SEL_UPPER;
	assign wr_lo  = reg_write && reg_addr == OFS_SEL_LOWER;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);
	////////////////////////////////////////////////////////////////////////////////
	a_reserved_read_zero: assert property ($past(reg_read) && ($past(reg_addr) == OFS_SEL_UPPER ||
		$past(reg_addr) == OFS_SEL_LOWER) |-> (reg_rdata & 16'h8888) == RST_ZERO) else $error("reserved bit set");
	a_dir_readback: assert property (wr_dir ##1 (reg_read && reg_addr == OFS_DIRECTION)
		|=> reg_rdata == $past(reg_wdata, 2)) else $error("direction readback wrong");
	a_dir_drives_pins: assert property (wr_dir ##1 !wr_dir |=> pin_oe[3:0] == $past(reg_wdata[3:0], 2))
		else $error("direction bit not applied");
	a_tx_route: assert property (wr_lo && reg_wdata[6:4] == MODE_TXD ##1 !wr_lo |=> pin_oe[PIN_TXD]
		&& pin_out[PIN_TXD] == $past(serial_transmit_line)) else $error("transmit not routed");
	a_clock_route: assert property (wr_lo && reg_wdata[10:8] == MODE_SCK ##1 !wr_lo |=>
		pin_oe[PIN_SCK] == $past(serial_clock_oe) && (!pin_oe[PIN_SCK] || pin_out[PIN_SCK] == $past(serial_clock_out)))
		else $error("clock not routed");
	a_rx_no_drive: assert property (wr_up && reg_wdata[14:12] == MODE_RXD ##1 !wr_up |=> !pin_oe[PIN_RXD])
		else $error("receive pin driven");
	a_rx_idle_level: assert property (wr_up && reg_wdata[14:12] != MODE_RXD ##1 !wr_up |=>
		serial_receive_line == RXD_IDLE) else $error("receive line not idle");
	a_clock_idle_level: assert property (wr_lo && reg_wdata[10:8] != MODE_SCK ##1 !wr_lo |=>
		serial_clock_in == SCK_IDLE) else $error("clock input not idle");
endmodule : pin_select_properties

bind port_e_pin_function_select pin_select_properties #(.PINS(PINS)) props (.ref_clk(ref_clk), .reset(reset),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
	.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .serial_transmit_line(serial_transmit_line),
	.serial_clock_out(serial_clock_out), .serial_clock_oe(serial_clock_oe),
	.serial_receive_line(serial_receive_line), .serial_clock_in(serial_clock_in));

// ==== test/serial_pin_partner.sv ====
// Purpose: Serial channel and outside-world pins around the selector.
// Assumes: Channel runs on ref_clk.
// Notes:   Outside levels act as pulls wherever no port drives.
`timescale 1ns/1ps
module serial_pin_partner
	import pin_mux_pkg::*;
(
	input  wire logic             ref_clk,
	input  wire logic [PIN_W-1:0] pin_out,
	input  wire logic [PIN_W-1:0] pin_oe,
	input  wire logic [PIN_W-1:0] ext_level,
	input  wire logic [2:0]       chan_next,
	output logic      [PIN_W-1:0] pin_in,
	output logic                  serial_transmit_line,
	output logic                  serial_clock_out,
	output logic                  serial_clock_oe
);
	initial begin
		{serial_clock_oe, serial_clock_out, serial_transmit_line} = 3'h0;
	end
	// Channel changes only after an edge, like an on-chip peer
	always @(posedge ref_clk) begin
		{serial_clock_oe, serial_clock_out, serial_transmit_line} <= chan_next;
	end
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule : serial_pin_partner

// ==== test/port_e_pin_function_select_bench.sv ====
// Purpose: Self-checking bench for the port E pin function selector.
// Assumes: Tasks are entered just after a rising edge.
// Notes:   Pin input waits cover the synchroniser delay.
`timescale 1ns/1ps
module port_e_pin_function_select_bench
	import pin_mux_pkg::*;
;
	logic              ref_clk, reset, reg_write, reg_read, rxd, sck_in, tx, ck, ck_oe;
	logic [ADDR_W-1:0] reg_addr;
	logic [DATA_W-1:0] reg_wdata, reg_rdata;
	logic [PIN_W-1:0]  pin_in, pin_out, pin_oe, ext_level;
	logic [2:0]        chan_next;
	int                mismatches, check_count;

	port_e_pin_function_select DUT (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe(pin_oe), .serial_transmit_line(tx), .serial_clock_out(ck), .serial_clock_oe(ck_oe),
		.serial_receive_line(rxd), .serial_clock_in(sck_in));
	serial_pin_partner peer (.ref_clk(ref_clk), .pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level),
		.chan_next(chan_next), .pin_in(pin_in), .serial_transmit_line(tx), .serial_clock_out(ck),
		.serial_clock_oe(ck_oe));

	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		reg_write <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_write <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_read <= 1'b0;
		#1;
		check(reg_rdata, e);
	endtask : rd
	task automatic idle(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : idle
	task automatic print_verdict;
		$display("Checks %0d, mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : print_verdict
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		rd(OFS_DIRECTION, RST_DIRECTION);
		rd(OFS_SEL_UPPER, RST_SEL_UPPER);
		rd(OFS_SEL_LOWER, RST_SEL_LOWER);
		check(pin_oe, RST_ZERO);
		check(pin_out, RST_ZERO);
		check(16'(rxd), 16'(RXD_IDLE));
		check(16'(sck_in), 16'(SCK_IDLE));
		$display("Test reset done");
	endtask : t_reset
	task automatic t_direction;
		wr(OFS_DIRECTION, 16'hA50F);
		rd(OFS_DIRECTION, 16'hA50F);
		check(pin_oe, 16'hA50F);
		wr(OFS_PORT_DATA, 16'h3C5A);
		idle(2);
		check(pin_out & pin_oe, 16'h240A);
		idle(6);
		rd(OFS_PIN_STATE, 16'h2E0A);
		$display("Test direction done");
	endtask : t_direction
	task automatic t_reserved;
		wr(OFS_SEL_UPPER, 16'hFFFF);
		wr(OFS_SEL_LOWER, 16'hFFFF);
		rd(OFS_SEL_UPPER, 16'h7777);
		rd(OFS_SEL_LOWER, 16'h7777);
		rd(8'h40, RST_ZERO);
		$display("Test reserved done");
	endtask : t_reserved
	task automatic t_serial;
		wr(OFS_DIRECTION, 16'h0000);
		wr(OFS_SEL_LOWER, 16'h0220);
		chan_next <= 3'h7;
		idle(3);
		check(pin_oe & 16'h0060, 16'h0060);
		check(pin_out & 16'h0060, 16'h0060);
		rd(OFS_ROUTE_STAT, 16'h0006);
		chan_next <= 3'h0;
		ext_level <= 16'h0F4F;
		idle(8);
		check(pin_oe & 16'h0060, 16'h0020);
		check(pin_out & 16'h0020, 16'h0000);
		check(16'(sck_in), 16'h0001);
		wr(OFS_SEL_LOWER, 16'h0010);
		idle(2);
		check(pin_oe & 16'h0060, 16'h0000);
		check(16'(sck_in), 16'(SCK_IDLE));
		$display("Test serial done");
	endtask : t_serial
	task automatic t_receive;
		wr(OFS_DIRECTION, 16'h0800);
		wr(OFS_SEL_UPPER, 16'h3000);
		ext_level <= 16'h074F;
		idle(8);
		check(16'(rxd), 16'h0000);
		check(pin_oe & 16'h0800, 16'h0000);
		rd(OFS_ROUTE_STAT, 16'h0001);
		wr(OFS_SEL_UPPER, 16'h0000);
		idle(2);
		check(16'(rxd), 16'(RXD_IDLE));
		check(pin_oe & 16'h0800, 16'h0800);
		reset <= 1'b1;
		idle(2);
		reset <= 1'b0;
		idle(1);
		rd(OFS_DIRECTION, RST_DIRECTION);
		check(16'(rxd), 16'(RXD_IDLE));
		$display("Test receive done");
	endtask : t_receive
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (5000) @(posedge ref_clk);
		mismatches++;
		print_verdict();
	end
	initial begin
		{reset, reg_write, reg_read, reg_addr, reg_wdata} = {1'b1, 2'b00, 8'h00, 16'h0000};
		{ext_level, chan_next, mismatches, check_count} = {16'h0F0F, 3'h0, 0, 0};
		repeat (4) @(posedge ref_clk);
		reset <= 1'b0;
		idle(1);
		t_reset();
		t_direction();
		t_reserved();
		t_serial();
		t_receive();
		print_verdict();
	end
endmodule : port_e_pin_function_select_bench
